/* File: hw/trc_tape_read_engine.sv */
`timescale 1ns/1ps

module trc_tape_read_engine (
    input  wire logic                       sys_clk,
    input  wire logic                       rst,
    input  wire logic                       cmd_valid,
    input  wire trc_pkg::trc_cdb_type       cmd_block,
    input  wire logic                       sense_request,
    input  wire logic                       cfg_fixed_mode,
    input  wire logic [23:0]                cfg_block_len,
    input  wire logic                       cfg_no_disconnect,
    input  wire logic                       cart_loaded,
    input  wire logic                       write_space_req,
    input  wire logic                       logical_tape_end_warning,
    input  wire logic                       blk_info_valid,
    input  wire trc_pkg::trc_blk_info_type  blk_info,
    input  wire logic                       tape_byte_valid,
    input  wire logic [7:0]                 tape_byte,
    input  wire logic                       host_ready,
    output logic                            blk_req_r,
    output logic                            byte_req_r,
    output logic                            host_valid_r,
    output logic [7:0]                      host_data_r,
    output logic                            cmd_done_r,
    output logic                            check_condition_r,
    output logic                            busy_r,
    output logic                            early_warning_r,
    output logic [3:0]                      servo_offset_r,
    output trc_pkg::trc_sense_type          sense_r
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        TRC_IDLE   = 3'b000,
        TRC_CHECK  = 3'b001,
        TRC_REQ    = 3'b010,
        TRC_WAIT   = 3'b011,
        TRC_XFER   = 3'b100,
        TRC_ENDBLK = 3'b101
    } trc_state_type;

    typedef struct packed {
        trc_state_type          st;
        logic                   fixed;
        logic                   suppress;
        logic [23:0]            req_len;
        logic [23:0]            blocks_done;
        logic [23:0]            blk_len;
        logic [23:0]            bytes_in;
        logic [23:0]            bytes_sent;
        logic [23:0]            send_len;
        logic [3:0]             attempts;
        logic [3:0]             servo;
        logic                   pend;
        logic                   blk_req;
        logic                   byte_req;
        logic                   host_valid;
        logic [7:0]             host_data;
        logic                   done;
        logic                   chk;
        logic                   warn;
        logic                   busy;
        logic                   sense_load;
        trc_pkg::trc_sense_type sense;
    } trc_eng_state_type;

    trc_eng_state_type s_r;
    trc_eng_state_type s_nxt;
    logic              sense_clear;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] diff32(input logic [23:0] a, input logic [23:0] b);
        return {8'h00, a} - {8'h00, b};
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic                   err;
        trc_pkg::trc_sense_type es;
        logic                   good;
        logic [23:0]            max_len;
        logic [23:0]            remaining;
        logic [23:0]            done_inc;

        err       = 1'b0;
        es        = '0;
        good      = 1'b0;
        s_nxt     = s_r;
        max_len   = cfg_no_disconnect ? trc_pkg::MAX_BLOCK_ND : trc_pkg::MAX_BLOCK;
        // Unsent count: whole request in variable mode, blocks left in fixed
        remaining = s_r.fixed ? (s_r.req_len - s_r.blocks_done) : s_r.req_len;
        done_inc  = s_r.blocks_done + 24'h000001;

        s_nxt.blk_req    = 1'b0;
        s_nxt.byte_req   = 1'b0;
        s_nxt.done       = 1'b0;
        s_nxt.sense_load = 1'b0;

        if (s_r.host_valid && host_ready) begin
            s_nxt.host_valid = 1'b0;
        end

        // Warning is only reported, the read goes on
        if (logical_tape_end_warning) begin
            s_nxt.warn = 1'b1;
        end

        // Tracking back to normal ahead of any write or space requested while idle
        if (write_space_req && s_r.st == TRC_IDLE) begin
            s_nxt.servo = trc_pkg::SERVO_NORMAL;
        end

        case (s_r.st)
            TRC_IDLE: begin
                if (cmd_valid && cmd_block.opcode == trc_pkg::OP_READ) begin
                    s_nxt.fixed       = cmd_block.flags[trc_pkg::FIXED_BIT];
                    s_nxt.suppress    = cmd_block.flags[trc_pkg::SUPPRESS_BIT];
                    s_nxt.req_len     = cmd_block.length;
                    s_nxt.blocks_done = 24'h000000;
                    s_nxt.attempts    = 4'h0;
                    s_nxt.chk         = 1'b0;
                    s_nxt.warn        = logical_tape_end_warning;
                    s_nxt.st          = TRC_CHECK;
                end
            end

            TRC_CHECK: begin
                if (!cart_loaded) begin
                    err    = 1'b1;
                    es.key = trc_pkg::KEY_NOT_READY;
                end else if (s_r.fixed && s_r.suppress) begin
                    err    = 1'b1;
                    es.key = trc_pkg::KEY_ILLEGAL;
                end else if (s_r.fixed != cfg_fixed_mode) begin
                    err    = 1'b1;
                    es.key = trc_pkg::KEY_ILLEGAL;
                end else if (s_r.req_len == 24'h000000) begin
                    good = 1'b1;
                end else if (!s_r.fixed && !s_r.suppress && s_r.req_len > max_len) begin
                    err                     = 1'b1;
                    es.valid                = 1'b1;
                    es.length_mismatch_flag = 1'b1;
                    es.key                  = trc_pkg::KEY_NO_SENSE;
                    es.info                 = diff32(s_r.req_len, max_len);
                end else begin
                    s_nxt.st = TRC_REQ;
                end
            end

            TRC_REQ: begin
                s_nxt.blk_req = 1'b1;
                s_nxt.st      = TRC_WAIT;
            end

            TRC_WAIT: begin
                if (blk_info_valid) begin
                    case (blk_info.kind)
                        trc_pkg::TRC_BLK_FMARK: begin
                            // Tape side parks past the mark before reporting it
                            err              = 1'b1;
                            es.valid         = 1'b1;
                            es.mark_hit_flag = 1'b1;
                            es.key           = trc_pkg::KEY_NO_SENSE;
                            es.info          = {8'h00, remaining};
                        end
                        trc_pkg::TRC_BLK_BLANK: begin
                            err      = 1'b1;
                            es.valid = 1'b1;
                            es.key   = trc_pkg::KEY_BLANK;
                            es.info  = {8'h00, remaining};
                        end
                        trc_pkg::TRC_BLK_PHYSICAL_TAPE_END: begin
                            err                  = 1'b1;
                            es.valid             = 1'b1;
                            es.media_end_flag    = 1'b1;
                            es.physical_tape_end = 1'b1;
                            es.key               = trc_pkg::KEY_MEDIUM;
                            es.info              = {8'h00, remaining};
                        end
                        default: begin
                            if (blk_info.ecc_bad && !blk_info.rewritten) begin
                                if (s_r.attempts == trc_pkg::READ_ATTEMPTS - 4'h1) begin
                                    err      = 1'b1;
                                    es.valid = 1'b1;
                                    es.key   = trc_pkg::KEY_MEDIUM;
                                    es.info  = {8'h00, remaining};
                                end else begin
                                    s_nxt.attempts = s_r.attempts + 4'h1;
                                    s_nxt.servo    = s_r.attempts + 4'h1;
                                    s_nxt.st       = TRC_REQ;
                                end
                            end else begin
                                s_nxt.attempts   = 4'h0;
                                s_nxt.blk_len    = blk_info.length;
                                s_nxt.bytes_in   = 24'h000000;
                                s_nxt.bytes_sent = 24'h000000;
                                if (s_r.fixed) begin
                                    s_nxt.send_len = cfg_block_len;
                                end else if (blk_info.length < s_r.req_len) begin
                                    s_nxt.send_len = blk_info.length;
                                end else begin
                                    s_nxt.send_len = s_r.req_len;
                                end
                                s_nxt.st = TRC_XFER;
                            end
                        end
                    endcase
                end
            end

            TRC_XFER: begin
                // One byte in flight keeps every output a plain flop
                if (s_r.bytes_in == s_r.blk_len) begin
                    s_nxt.st = TRC_ENDBLK;
                end else if (!s_r.pend && !s_r.host_valid) begin
                    s_nxt.byte_req = 1'b1;
                    s_nxt.pend     = 1'b1;
                end
                if (s_r.pend && tape_byte_valid) begin
                    s_nxt.pend     = 1'b0;
                    s_nxt.bytes_in = s_r.bytes_in + 24'h000001;
                    if (s_r.bytes_sent < s_r.send_len) begin
                        s_nxt.host_valid = 1'b1;
                        s_nxt.host_data  = tape_byte;
                        s_nxt.bytes_sent = s_r.bytes_sent + 24'h000001;
                    end
                end
            end

            TRC_ENDBLK: begin
                if (!s_r.host_valid) begin
                    if (s_r.fixed) begin
                        if (s_r.blk_len != cfg_block_len) begin
                            err                     = 1'b1;
                            es.valid                = 1'b1;
                            es.length_mismatch_flag = 1'b1;
                            es.key                  = trc_pkg::KEY_NO_SENSE;
                            es.info                 = diff32(s_r.req_len, done_inc);
                        end else begin
                            s_nxt.blocks_done = done_inc;
                            if (done_inc == s_r.req_len) begin
                                good = 1'b1;
                            end else begin
                                s_nxt.st = TRC_REQ;
                            end
                        end
                    end else if (s_r.blk_len != s_r.req_len && !s_r.suppress) begin
                        err                     = 1'b1;
                        es.valid                = 1'b1;
                        es.length_mismatch_flag = 1'b1;
                        es.key                  = trc_pkg::KEY_NO_SENSE;
                        es.info                 = diff32(s_r.req_len, s_r.blk_len);
                    end else begin
                        good = 1'b1;
                    end
                end
            end

            default: begin
                s_nxt.st = TRC_IDLE;
            end
        endcase

        if (err) begin
            s_nxt.sense      = es;
            s_nxt.sense_load = 1'b1;
            s_nxt.chk        = 1'b1;
            s_nxt.done       = 1'b1;
            s_nxt.st         = TRC_IDLE;
        end else if (good) begin
            s_nxt.chk  = 1'b0;
            s_nxt.done = 1'b1;
            s_nxt.st   = TRC_IDLE;
        end
        s_nxt.busy = (s_nxt.st != TRC_IDLE);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Sense holding
    // ------------------------------------------------------------
    // Any new command drops old sense, read or not
    assign sense_clear = sense_request | cmd_valid;

    trc_sense_hold u_sense (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .load     (s_r.sense_load),
        .sense_in (s_r.sense),
        .clear    (sense_clear),
        .sense_r  (sense_r)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign blk_req_r         = s_r.blk_req;
    assign byte_req_r        = s_r.byte_req;
    assign host_valid_r      = s_r.host_valid;
    assign host_data_r       = s_r.host_data;
    assign cmd_done_r        = s_r.done;
    assign check_condition_r = s_r.chk;
    assign busy_r            = s_r.busy;
    assign early_warning_r   = s_r.warn;
    assign servo_offset_r    = s_r.servo;

endmodule

/* File: hw/trc_pkg.sv */
package trc_pkg;

    // ------------------------------------------------------------
    // Command block layout
    // ------------------------------------------------------------
    localparam logic [7:0]  OP_READ        = 8'h08;
    localparam int          FIXED_BIT      = 0;
    localparam int          SUPPRESS_BIT   = 1;

    // ------------------------------------------------------------
    // Sense keys
    // ------------------------------------------------------------
    localparam logic [3:0]  KEY_NO_SENSE   = 4'h0;
    localparam logic [3:0]  KEY_NOT_READY  = 4'h2;
    localparam logic [3:0]  KEY_MEDIUM     = 4'h3;
    localparam logic [3:0]  KEY_ILLEGAL    = 4'h5;
    localparam logic [3:0]  KEY_BLANK      = 4'h8;

    // ------------------------------------------------------------
    // Limits and reset values
    // ------------------------------------------------------------
    localparam logic [23:0] MAX_BLOCK      = 24'h03c000;
    localparam logic [23:0] MAX_BLOCK_ND   = 24'h028000;
    localparam logic [3:0]  READ_ATTEMPTS  = 4'ha;
    localparam logic [3:0]  SERVO_NORMAL   = 4'h0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  opcode;
        logic [7:0]  flags;
        logic [23:0] length;
        logic [7:0]  control;
    } trc_cdb_type;

    typedef enum logic [1:0] {
        TRC_BLK_DATA  = 2'b00,
        TRC_BLK_FMARK = 2'b01,
        TRC_BLK_BLANK = 2'b10,
        TRC_BLK_PHYSICAL_TAPE_END  = 2'b11
    } trc_blk_kind_type;

    typedef struct packed {
        trc_blk_kind_type kind;
        logic [23:0]      length;
        logic             ecc_bad;
        logic             rewritten;
    } trc_blk_info_type;

    typedef struct packed {
        logic        valid;
        logic        mark_hit_flag;
        logic        media_end_flag;
        logic        physical_tape_end;
        logic        length_mismatch_flag;
        logic [3:0]  key;
        logic [31:0] info;
    } trc_sense_type;

endpackage

/* File: hw/trc_sense_hold.sv */
`timescale 1ns/1ps

module trc_sense_hold (
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    input  wire logic                   load,
    input  wire trc_pkg::trc_sense_type sense_in,
    input  wire logic                   clear,
    output trc_pkg::trc_sense_type      sense_r
);

    // ------------------------------------------------------------
    // Sense holding register
    // ------------------------------------------------------------
    typedef struct packed {
        trc_pkg::trc_sense_type sense;
    } trc_hold_state_type;

    trc_hold_state_type s_r;
    trc_hold_state_type s_nxt;

    // Load wins so a fresh error is never lost to a clear
    always_comb begin
        s_nxt = s_r;
        if (load) begin
            s_nxt.sense = sense_in;
        end else if (clear) begin
            s_nxt.sense = '0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sense_r = s_r.sense;

endmodule

/* File: tb/trc_read_chk.sv */
`timescale 1ns/1ps

module trc_read_chk (
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    input  wire logic                   cmd_valid,
    input  wire trc_pkg::trc_cdb_type   cmd_block,
    input  wire logic                   sense_request,
    input  wire logic                   cfg_fixed_mode,
    input  wire logic                   cfg_no_disconnect,
    input  wire logic                   cart_loaded,
    input  wire logic                   write_space_req,
    input  wire logic                   blk_req_r,
    input  wire logic                   cmd_done_r,
    input  wire logic                   check_condition_r,
    input  wire logic                   busy_r,
    input  wire logic [3:0]             servo_offset_r,
    input  wire trc_pkg::trc_sense_type sense_r
);
    // ----
    // Decode
    // ----
    logic        go;
    logic        ok;
    logic        fin;
    logic [23:0] lim;
    logic [23:0] over_r;
    assign go  = cmd_valid && !busy_r && cmd_block.opcode == trc_pkg::OP_READ;
    assign ok  = go && cart_loaded && cmd_block.flags[1:0] != 2'b11 && cmd_block.flags[0] == cfg_fixed_mode;
    assign lim = cfg_no_disconnect ? trc_pkg::MAX_BLOCK_ND : trc_pkg::MAX_BLOCK;
    assign fin = cmd_done_r && check_condition_r;
    // Excess latched at take; limit may move
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst)
            over_r <= 24'h0;
        else if (go)
            over_r <= cmd_block.length - lim;
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // ----
    // Properties
    // ----
    a_not_ready: assert property (go && !cart_loaded
        |-> ##2 fin ##1 sense_r.key == trc_pkg::KEY_NOT_READY)
        else $error("unloaded read not refused");
    a_fixed_suppress: assert property (go && cart_loaded && cmd_block.flags[1:0] == 2'b11
        |-> ##2 fin ##1 sense_r.key == trc_pkg::KEY_ILLEGAL)
        else $error("fixed with suppress not refused");
    a_mode_clash: assert property (go && cart_loaded && cmd_block.flags[1:0] == 2'b01 && !cfg_fixed_mode
        |-> ##2 fin ##1 sense_r.key == trc_pkg::KEY_ILLEGAL)
        else $error("mode clash not refused");
    a_zero_len: assert property (ok && cmd_block.length == 24'h0
        |=> !blk_req_r ##1 !blk_req_r && cmd_done_r && !check_condition_r)
        else $error("zero length read misbehaved");
    a_oversize_len: assert property (ok && cmd_block.flags[1:0] == 2'b00 && cmd_block.length > lim
        |-> ##2 fin
        ##1 sense_r.length_mismatch_flag && sense_r.key == 4'h0 && sense_r.info == {8'h00, over_r})
        else $error("oversize read not reported");
    a_other_op: assert property (cmd_valid && !busy_r && cmd_block.opcode != trc_pkg::OP_READ |=> !busy_r)
        else $error("non read opcode started work");
    a_servo_cap: assert property (busy_r |-> servo_offset_r < 4'ha)
        else $error("servo offset beyond reread count");
    a_servo_home: assert property (write_space_req && !busy_r |=> servo_offset_r == trc_pkg::SERVO_NORMAL)
        else $error("tracking not restored");
    a_sense_hold: assert property (sense_r.valid && !cmd_valid && !sense_request && !cmd_done_r
        |=> $stable(sense_r))
        else $error("held sense changed");
endmodule

bind trc_tape_read_engine trc_read_chk u_chk (.*);

/* File: tb/trc_tape_model.sv */
`timescale 1ns/1ps

module trc_tape_model (
    input  wire logic                      sys_clk,
    input  wire logic                      rst,
    input  wire logic                      blk_req_r,
    input  wire logic                      byte_req_r,
    input  wire logic                      cmd_done_r,
    input  wire trc_pkg::trc_blk_kind_type t_kind,
    input  wire logic [23:0]               t_len,
    input  wire logic [3:0]                t_nbad,
    input  wire logic                      t_slow,
    output trc_pkg::trc_blk_info_type      blk_info,
    output logic                           blk_info_valid,
    output logic [7:0]                     tape_byte,
    output logic                           tape_byte_valid
);
    logic [2:0] bwait;
    logic       bpend;
    logic       dpend;
    logic [3:0] nfail;
    logic [7:0] seq;
    // Idle lines toggle so a stale value is never read as fresh
    // Parking past a mark is the tape side's job
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            {bwait, bpend, dpend, nfail, seq, blk_info_valid, tape_byte_valid, blk_info, tape_byte} <= '0;
        end else begin
            blk_info_valid  <= 1'b0;
            tape_byte_valid <= 1'b0;
            blk_info        <= ~blk_info;
            tape_byte       <= ~tape_byte;
            if (blk_req_r) begin
                bpend <= 1'b1;
                bwait <= t_slow ? 3'h5 : 3'h0;
            end else if (bpend && bwait != 3'h0) begin
                bwait <= bwait - 3'h1;
            end else if (bpend) begin
                // No rewritten copy ever, so each failure costs a reread
                bpend          <= 1'b0;
                blk_info_valid <= 1'b1;
                blk_info       <= {t_kind, t_len, nfail < t_nbad, 1'b0};
                nfail          <= (nfail < t_nbad) ? nfail + 4'h1 : 4'h0;
                seq            <= 8'h00;
            end
            if (byte_req_r)
                dpend <= 1'b1;
            else if (dpend) begin
                dpend           <= 1'b0;
                tape_byte_valid <= 1'b1;
                tape_byte       <= seq;
                seq             <= seq + 8'h01;
            end
            if (cmd_done_r)
                nfail <= 4'h0;
        end
    end
endmodule

/* File: tb/trc_tape_read_engine_tb.sv */
`timescale 1ns/1ps

module trc_tape_read_engine_tb;
    logic                       sys_clk, rst, cmd_valid, sense_request, cfg_fixed_mode, cfg_no_disconnect;
    logic                       cart_loaded, write_space_req, logical_tape_end_warning, hstall, t_slow;
    logic                       blk_info_valid, tape_byte_valid, blk_req_r, byte_req_r, host_valid_r;
    logic                       cmd_done_r, check_condition_r, busy_r, early_warning_r;
    logic                       host_ready = 1'b1;
    logic [7:0]                 tape_byte, host_data_r, nexp;
    logic [3:0]                 servo_offset_r, t_nbad;
    logic [23:0]                cfg_block_len, t_len;
    trc_pkg::trc_cdb_type       cmd_block;
    trc_pkg::trc_blk_info_type  blk_info;
    trc_pkg::trc_blk_kind_type  t_kind;
    trc_pkg::trc_sense_type     sense_r;
    int                         fail_count, n_checks, nbyte, nblk;
    localparam logic [40:0]     ALL = {41{1'b1}};
    localparam logic [40:0]     KEY = {9'h00f, 32'h0};

    trc_tape_read_engine dut (.*);
    trc_tape_model tape (.*);
    // ----
    // Shared tasks
    // ----
    task automatic chk(input logic [40:0] seen, input logic [40:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic run(input logic [7:0] fl, input logic [23:0] len, input logic cc, input logic [40:0] m,
                       input logic [40:0] exp);
        int i;
        @(negedge sys_clk);
        nbyte     = 0;
        nblk      = 0;
        cmd_block = '{8'h08, fl, len, 8'h00};
        cmd_valid = 1'b1;
        @(negedge sys_clk);
        cmd_valid = 1'b0;
        for (i = 0; i < 3000 && cmd_done_r !== 1'b1; i++)
            @(negedge sys_clk);
        chk(41'(i < 3000), 41'd1);
        chk(41'(check_condition_r), 41'(cc));
        @(negedge sys_clk);
        chk(sense_r & m, exp);
    endtask
    // Host stalls alternate cycles
    always @(negedge sys_clk)
        host_ready <= !hstall || !host_ready;
    always @(posedge sys_clk) begin
        if (blk_info_valid === 1'b1)
            nexp = 8'h00;
        if (blk_req_r === 1'b1)
            nblk++;
        if (host_valid_r === 1'b1 && host_ready === 1'b1) begin
            chk(41'(host_data_r), 41'(nexp));
            nexp++;
            nbyte++;
        end
    end
    // ----
    // Scenarios
    // ----
    task automatic s_refuse();
        cart_loaded = 1'b0;
        run(8'h00, 24'h10, 1'b1, KEY, {9'h002, 32'h0});
        cart_loaded = 1'b1;
        for (int n = 0; n < 3; n++) begin
            cfg_fixed_mode = n < 2;
            run(8'((n + 3) % 4), 24'h4, 1'b1, KEY, {9'h005, 32'h0});
        end
        cmd_block.opcode = 8'h0a;
        cmd_valid        = 1'b1;
        @(negedge sys_clk);
        cmd_valid = 1'b0;
        chk(41'(busy_r), 41'd0);
        run(8'h00, 24'h0, 1'b0, ALL, 41'h0);
        chk(41'(nblk), 41'd0);
        for (int n = 0; n < 2; n++) begin
            cfg_no_disconnect = n[0];
            run(8'h00, n[0] ? 24'h028003 : 24'h03c003, 1'b1, ALL, {9'h110, 32'h3});
        end
    endtask
    task automatic s_data();
        logical_tape_end_warning = 1'b1;
        hstall                   = 1'b1;
        run(8'h00, 24'h4, 1'b0, ALL, 41'h0);
        chk(41'(nbyte), 41'd4);
        chk(41'(early_warning_r), 41'd1);
        run(8'h00, 24'h6, 1'b1, ALL, {9'h110, 32'h2});
        run(8'h00, 24'h2, 1'b1, ALL, {9'h110, 32'hfffffffe});
        run(8'h02, 24'h2, 1'b0, ALL, 41'h0);
        chk(41'(nbyte), 41'd2);
        cfg_fixed_mode = 1'b1;
        t_slow         = 1'b1;
        t_len          = 24'h3;
        run(8'h01, 24'h2, 1'b0, ALL, 41'h0);
        chk(41'(nbyte), 41'd6);
        t_len = 24'h4;
        run(8'h01, 24'h2, 1'b1, ALL, {9'h110, 32'h1});
        t_kind = trc_pkg::TRC_BLK_FMARK;
        run(8'h01, 24'h3, 1'b1, ALL, {9'h180, 32'h3});
        cfg_fixed_mode = 1'b0;
    endtask
    task automatic s_stops();
        logic [8:0] fl [3] = '{9'h180, 9'h108, 9'h163};
        // Suppress set: stops still report
        for (int i = 0; i < 3; i++) begin
            t_kind = trc_pkg::trc_blk_kind_type'(i + 1);
            run(8'h02, 24'h5, 1'b1, ALL, {fl[i], 32'h5});
        end
        t_kind = trc_pkg::TRC_BLK_DATA;
        t_len  = 24'h4;
        t_nbad = 4'h3;
        run(8'h00, 24'h4, 1'b0, ALL, 41'h0);
        chk(41'(nblk), 41'd4);
        chk(41'(servo_offset_r), 41'd3);
        write_space_req = 1'b1;
        @(negedge sys_clk);
        write_space_req = 1'b0;
        @(negedge sys_clk);
        chk(41'(servo_offset_r), 41'd0);
        t_nbad = 4'hf;
        run(8'h00, 24'h4, 1'b1, ALL, {9'h103, 32'h4});
        chk(41'(nblk), 41'd10);
        repeat (5) @(negedge sys_clk);
        chk(41'(sense_r.valid), 41'd1);
        sense_request = 1'b1;
        @(negedge sys_clk);
        sense_request = 1'b0;
        @(negedge sys_clk);
        chk(41'(sense_r.valid), 41'd0);
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    initial begin
        #200000;
        fail_count++;
        $display("BAD %0t watchdog expired", $time);
        stop_test();
    end
    initial begin
        {cmd_valid, sense_request, cfg_fixed_mode, cfg_no_disconnect, write_space_req, hstall, t_slow} = '0;
        {logical_tape_end_warning, fail_count, n_checks, nbyte, nblk, nexp, t_nbad, cmd_block} = '0;
        rst           = 1'b1;
        cart_loaded   = 1'b1;
        cfg_block_len = 24'h3;
        t_len         = 24'h4;
        t_kind        = trc_pkg::TRC_BLK_DATA;
        repeat (12) @(negedge sys_clk);
        rst = 1'b0;
        s_refuse();
        s_data();
        s_stops();
        stop_test();
    end
endmodule
